// ### pbs_array.sv
`timescale 1ns/1ps
// storage array with per-lane writes
module pbs_array #(
	parameter int ADDR_W = pbs_pkg::ADDR_W,
	parameter int LANES  = pbs_pkg::LANES,
	parameter int LANE_W = pbs_pkg::LANE_W
) (
	input  wire logic                    core_clk,
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic [LANES-1:0]        lane_wr,
	input  wire logic [LANES*LANE_W-1:0] wdata,
	output logic      [LANES*LANE_W-1:0] rdata
);
	logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

	// asynchronous read feeds the output register
	assign rdata = mem[addr];

	// one write port per lane
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			always_ff @(posedge core_clk) begin
				if (lane_wr[g]) begin
					mem[addr][g*LANE_W +: LANE_W] <= wdata[g*LANE_W +: LANE_W];
				end
			end
		end
	endgenerate
endmodule

// ### pbs_burst.sv
`timescale 1ns/1ps
// two-bit wraparound burst counter
module pbs_burst (
	input  wire logic                        core_clk,
	input  wire logic                        arst_n,
	input  wire logic                        load,
	input  wire logic [pbs_pkg::BURST_W-1:0] start,
	input  wire logic                        step,
	input  wire logic                        linear,
	output logic      [pbs_pkg::BURST_W-1:0] low_bits
);
	typedef struct packed {
		logic [pbs_pkg::BURST_W-1:0] base;
		logic [pbs_pkg::BURST_W-1:0] cnt;
	} pbs_burst_st_t;
	pbs_burst_st_t s_q, s_d;

	// next counter state
	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.base = start;
			s_d.cnt  = pbs_pkg::BURST_RST;
		end else if (step) begin
			s_d.cnt = s_q.cnt + 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// linear adds, interleaved xors
	assign low_bits = linear ? s_q.base + s_q.cnt : s_q.base ^ s_q.cnt;
endmodule

// ### pbs_host.sv
`timescale 1ns/1ps
// master on the far side of the memory pins
module pbs_host (
	input  wire logic                       core_clk,
	input  wire logic                       data_oe,
	input  wire logic [pbs_pkg::DATA_W-1:0] data_out,
	output pbs_pkg::pbs_bus_t               bus,
	output logic                            oe_n,
	output logic                            strap_n,
	output logic      [pbs_pkg::DATA_W-1:0] data_in
);
	localparam pbs_pkg::pbs_bus_t IDLE = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hF,
		1'h0, 1'h1, 1'h0, '0, '0};
	logic [pbs_pkg::DATA_W:0] log[$];
	initial begin
		bus = IDLE;
		oe_n = 1'h1;
		strap_n = 1'h1;
	end
	// shared wire: device, writing master, else a stale inverted value
	assign data_in = data_oe ? data_out : (!bus.all_wr_n || !bus.lane_we_n) ? bus.wdata : ~bus.wdata;
	// record the pins, then change the request after the falling edge
	task automatic cyc(pbs_pkg::pbs_bus_t b, logic oe = 1'h0);
		@(negedge core_clk);
		log.push_back({data_oe, data_out});
		bus = b;
		oe_n = oe;
	endtask
	task automatic idle(int k);
		repeat (k) cyc(IDLE);
	endtask
endmodule

// ### pbs_pkg.sv
package pbs_pkg;
	// widths of the memory word and address
	localparam int ADDR_W     = 10;
	localparam int LANES      = 4;
	localparam int LANE_W     = 9;
	localparam int DATA_W     = LANES * LANE_W;
	// burst counter width and reset values
	localparam int BURST_W    = 2;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [1:0] ACC_IDLE  = 2'h0;
	localparam logic [1:0] ACC_READ  = 2'h1;
	localparam logic [1:0] ACC_WRITE = 2'h2;

	// registered bus-side inputs
	typedef struct packed {
		logic              proc_as_n;
		logic              ctrl_as_n;
		logic              step_n;
		logic              all_wr_n;
		logic              lane_we_n;
		logic [LANES-1:0]  lane_sel_n;
		logic              sel1_n;
		logic              sel2;
		logic              sel3_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pbs_bus_t;

	// pin group of the data and parity lines
	typedef struct packed {
		logic [DATA_W-1:0] dout;
		logic              oe;
	} pbs_pins_t;
endpackage

// ### pbs_sram.sv
`timescale 1ns/1ps
// What this block does
// - data pins used as inputs are captured into a data register on clock rise
// - read drives the word addressed at the previous clock rise
// - data pins drive while output enable low, float while high
// - strap low gives linear burst order, high gives interleaved
// - every synchronous input is registered on the rising edge
// - read data passes through a rising-edge output register
// - either processor or controller address strobe starts an access
// - start address loads a two-bit wraparound burst counter
// - a lane is written with lane enable and its select, or by global write
// - global write writes every lane regardless of lane controls
// - processor strobe ignored while first select is high
// - read starts on strobe, all selects active, both write inputs high
// - read start stores the address in register and burst logic
// - next edge clocks fetched data out when output enable low
// - first cycle after deselect stays floating whatever output enable does
// - single reads may follow back to back
// - deselect by selects with a strobe floats the outputs at once
// - selects are sampled, output enable is sampled straight into the driver flip-flop
// - both strobes together with first select low: processor strobe alone is acted on
// - burst step low advances the counter for reads and writes
// - interleaved order xors start bits with count 0 to 3
// - linear order adds one modulo four per advance
module pbs_sram #(
	parameter int ADDR_W = pbs_pkg::ADDR_W,
	parameter int LANES  = pbs_pkg::LANES,
	parameter int LANE_W = pbs_pkg::LANE_W
) (
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire logic                    processor_addr_strobe_n,
	input  wire logic                    controller_addr_strobe_n,
	input  wire logic                    burst_step_n,
	input  wire logic                    all_bytes_write_n,
	input  wire logic                    lane_write_enable_n,
	input  wire logic [LANES-1:0]        lane_select_n,
	input  wire logic                    select_first_n,
	input  wire logic                    select_second,
	input  wire logic                    select_third_n,
	input  wire logic                    order_linear_n,
	input  wire logic                    out_enable_n,
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic [LANES*LANE_W-1:0] data_in,
	output logic      [LANES*LANE_W-1:0] data_out,
	output logic                         data_oe
);
	localparam int DW = LANES * LANE_W;

	// one-hot access state
	typedef enum logic [2:0] {
		PBS_DESEL  = 3'h1,
		PBS_FIRST  = 3'h2,
		PBS_ACTIVE = 3'h4
	} pbs_state_t;

	typedef struct packed {
		logic              proc_as_n;
		logic              ctrl_as_n;
		logic              step_n;
		logic              all_wr_n;
		logic              lane_we_n;
		logic [LANES-1:0]  lane_sel_n;
		logic              sel1_n;
		logic              sel2;
		logic              sel3_n;
		logic [ADDR_W-1:0] addr;
		logic [DW-1:0]     wdata;
	} pbs_in_t;

	typedef struct packed {
		pbs_in_t           in;
		pbs_state_t        state;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        access;
		logic              linear;
		logic              strap_seen;
		logic [DW-1:0]     dout;
		logic              drive;
		logic              oe_pin;
	} pbs_st_t;

	pbs_st_t s_q, s_d;

	logic                        selected;
	logic                        proc_start;
	logic                        ctrl_start;
	logic                        start;
	logic                        deselect;
	logic                        wr_cycle;
	logic                        burst_step;
	logic [pbs_pkg::BURST_W-1:0] low_bits;
	logic [ADDR_W-1:0]           arr_addr;
	logic [LANES-1:0]            lane_wr;
	logic [DW-1:0]               rdata;

	// decode of the registered strobes and selects
	always_comb begin
		selected   = !s_q.in.sel1_n && s_q.in.sel2 && !s_q.in.sel3_n;
		proc_start = !s_q.in.proc_as_n && !s_q.in.sel1_n;
		ctrl_start = s_q.in.proc_as_n && !s_q.in.ctrl_as_n;
		start      = (proc_start || ctrl_start) && selected;
		deselect   = (proc_start || !s_q.in.ctrl_as_n) && !selected;
		wr_cycle   = !s_q.in.all_wr_n || !s_q.in.lane_we_n;
		burst_step = !start && !s_q.in.step_n && (s_q.access != pbs_pkg::ACC_IDLE);
	end

	// array address: base word plus the burst low bits
	assign arr_addr = start ? s_q.in.addr
		: {s_q.addr[ADDR_W-1:pbs_pkg::BURST_W], low_bits};

	// lane write enables; a processor-strobe start ignores writes in its first cycle
	always_comb begin
		lane_wr = '0;
		if (((s_q.access != pbs_pkg::ACC_IDLE && !start) || (start && ctrl_start)) && !deselect) begin
			if (!s_q.in.all_wr_n) begin
				lane_wr = '1;
			end else if (!s_q.in.lane_we_n) begin
				lane_wr = ~s_q.in.lane_sel_n;
			end
		end
	end

	pbs_burst u_burst (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (start),
		.start    (s_q.in.addr[pbs_pkg::BURST_W-1:0]),
		.step     (burst_step),
		.linear   (s_q.linear),
		.low_bits (low_bits)
	);

	pbs_array #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_W)
	) u_array (
		.core_clk (core_clk),
		.addr     (arr_addr),
		.lane_wr  (lane_wr),
		.wdata    (s_q.in.wdata),
		.rdata    (rdata)
	);

	// next state of the whole port
	always_comb begin
		s_d = s_q;
		// input registers on every edge
		s_d.in.proc_as_n  = processor_addr_strobe_n;
		s_d.in.ctrl_as_n  = controller_addr_strobe_n;
		s_d.in.step_n     = burst_step_n;
		s_d.in.all_wr_n   = all_bytes_write_n;
		s_d.in.lane_we_n  = lane_write_enable_n;
		s_d.in.lane_sel_n = lane_select_n;
		s_d.in.sel1_n     = select_first_n;
		s_d.in.sel2       = select_second;
		s_d.in.sel3_n     = select_third_n;
		s_d.in.addr       = addr;
		s_d.in.wdata      = data_in;
		s_d.oe_pin        = out_enable_n;
		// strap caught once after reset release
		if (!s_q.strap_seen) begin
			s_d.linear     = !order_linear_n;
			s_d.strap_seen = 1'b1;
		end
		// access tracking
		if (deselect) begin
			s_d.access = pbs_pkg::ACC_IDLE;
			s_d.state  = PBS_DESEL;
		end else if (start) begin
			s_d.addr   = s_q.in.addr;
			s_d.access = (ctrl_start && wr_cycle) ? pbs_pkg::ACC_WRITE : pbs_pkg::ACC_READ;
			case (s_q.state)
				PBS_DESEL: s_d.state = PBS_FIRST;
				default:   s_d.state = PBS_ACTIVE;
			endcase
		end else begin
			if (s_q.access != pbs_pkg::ACC_IDLE && wr_cycle) begin
				s_d.access = pbs_pkg::ACC_WRITE;
			end
			case (s_q.state)
				PBS_FIRST: s_d.state = PBS_ACTIVE;
				default:   s_d.state = s_q.state;
			endcase
		end
		// output register loads fetched read data
		if (start || s_q.access == pbs_pkg::ACC_READ) begin
			s_d.dout = rdata;
		end
		// drivers: masked after deselect and during writes, else output enable
		s_d.drive = 1'b0;
		if (!deselect && (start ? !(ctrl_start && wr_cycle) : s_q.access == pbs_pkg::ACC_READ)
				&& !(start && s_q.state == PBS_DESEL)) begin
			s_d.drive = 1'b1;
		end
		if (!deselect && !start && s_q.access != pbs_pkg::ACC_IDLE && wr_cycle) begin
			s_d.drive = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q            <= '0;
			s_q.in.proc_as_n  <= 1'b1;
			s_q.in.ctrl_as_n  <= 1'b1;
			s_q.in.step_n     <= 1'b1;
			s_q.in.all_wr_n   <= 1'b1;
			s_q.in.lane_we_n  <= 1'b1;
			s_q.in.lane_sel_n <= '1;
			s_q.in.sel1_n     <= 1'b1;
			s_q.in.sel3_n     <= 1'b1;
			s_q.state      <= PBS_DESEL;
			s_q.access     <= pbs_pkg::ACC_IDLE;
			s_q.oe_pin     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= '0;
			data_oe  <= 1'b0;
		end else begin
			data_out <= s_d.dout;
			data_oe  <= s_d.drive && !out_enable_n;
		end
	end
endmodule

// ### pbs_sram_assertions.sv
`timescale 1ns/1ps
// pin checks on the burst memory port
module pbs_sram_assertions #(
	parameter int LANES  = pbs_pkg::LANES,
	parameter int LANE_W = pbs_pkg::LANE_W
) (
	input wire logic                    core_clk,
	input wire logic                    arst_n,
	input wire logic                    processor_addr_strobe_n,
	input wire logic                    controller_addr_strobe_n,
	input wire logic                    burst_step_n,
	input wire logic                    all_bytes_write_n,
	input wire logic                    lane_write_enable_n,
	input wire logic                    select_first_n,
	input wire logic                    select_second,
	input wire logic                    select_third_n,
	input wire logic                    out_enable_n,
	input wire logic [LANES*LANE_W-1:0] data_out,
	input wire logic                    data_oe
);
	logic sel, stb, rd, desel, quiet, step, desel_q;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// request decode as the pins show it at an edge
	assign sel   = !select_first_n && select_second && !select_third_n;
	assign stb   = !controller_addr_strobe_n || (!processor_addr_strobe_n && !select_first_n);
	assign rd    = stb && sel && all_bytes_write_n && lane_write_enable_n;
	assign desel = stb && !sel;
	assign quiet = processor_addr_strobe_n && controller_addr_strobe_n
		&& all_bytes_write_n && lane_write_enable_n;
	// a step reaches the pins one edge later than a strobe
	assign step  = !burst_step_n;
	// last access was a deselect
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			desel_q <= 1'h0;
		else if (stb)
			desel_q <= !sel;
	oe_float_a: assert property (out_enable_n |=> !data_oe)
		else $error("drive with enable high");
	desel_float_a: assert property (desel |-> ##2 !data_oe)
		else $error("drive after deselect");
	desel_hold_a: assert property (desel |-> ##2 $stable(data_out))
		else $error("load on deselect");
	back_read_a: assert property (rd ##1 rd ##1 !out_enable_n |=> data_oe)
		else $error("back to back read lost");
	first_float_a: assert property (rd && desel_q |-> ##2 !data_oe)
		else $error("first cycle driven");
	out_hold_a: assert property ($changed(data_out) |-> $past(stb, 2) || $past(step, 3))
		else $error("output changed unasked");
	proc_ignore_a: assert property (!processor_addr_strobe_n && select_first_n
		&& controller_addr_strobe_n && burst_step_n |-> ##2 $stable(data_out))
		else $error("strobe not ignored");
	both_strobe_a: assert property (rd ##1 (!processor_addr_strobe_n
		&& !controller_addr_strobe_n && sel && !all_bytes_write_n) ##1 quiet
		##1 !out_enable_n |=> data_oe)
		else $error("processor strobe not read");
	cover property (rd ##1 rd);
	cover property (desel);
	cover property (rd && desel_q);
endmodule
bind pbs_sram pbs_sram_assertions #(.LANES(LANES), .LANE_W(LANE_W)) chk_u (.*);

// ### tb_pipelined_sync_burst_sram_read_port.sv
`timescale 1ns/1ps
// bench: writes, bursts, strobes, deselect, output enable
module tb_pipelined_sync_burst_sram_read_port;
	typedef logic [pbs_pkg::DATA_W:0] pbs_pin_t;
	logic                       core_clk = 1'h0;
	logic                       arst_n = 1'h0;
	logic                       data_oe;
	logic                       oe_n;
	logic                       strap_n;
	logic [pbs_pkg::DATA_W-1:0] data_out;
	logic [pbs_pkg::DATA_W-1:0] data_in;
	pbs_pkg::pbs_bus_t          bus;
	pbs_pkg::pbs_bus_t          b;
	int                         miscompares = 0;
	int                         checks_done = 0;
	int                         n;
	always #5 core_clk = ~core_clk;
	pbs_host host_u (.core_clk(core_clk), .data_oe(data_oe), .data_out(data_out), .bus(bus),
		.oe_n(oe_n), .strap_n(strap_n), .data_in(data_in));
	pbs_sram dut_u (.core_clk(core_clk), .arst_n(arst_n), .processor_addr_strobe_n(bus.proc_as_n),
		.controller_addr_strobe_n(bus.ctrl_as_n), .burst_step_n(bus.step_n),
		.all_bytes_write_n(bus.all_wr_n), .lane_write_enable_n(bus.lane_we_n),
		.lane_select_n(bus.lane_sel_n), .select_first_n(bus.sel1_n), .select_second(bus.sel2),
		.select_third_n(bus.sel3_n), .order_linear_n(strap_n), .out_enable_n(oe_n),
		.addr(bus.addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	function automatic pbs_pkg::pbs_bus_t op(logic ps, logic cs, logic wr, logic st, int a);
		op = '{ps, cs, st, wr, 1'h1, 4'hF, 1'h0, 1'h1, 1'h0, a[pbs_pkg::ADDR_W-1:0], {4{9'(a - 7)}}};
	endfunction
	// stored word of address 8 plus i, lanes 0 and 2 of word 0 overwritten
	function automatic pbs_pin_t mem(int i);
		mem = {1'h1, {4{9'(i + 1)}} | (i == 0 ? 36'h007FC01FF : 36'h0)};
	endfunction
	function automatic pbs_pin_t lg(int i);
		lg = host_u.log[n + i + 2];
	endfunction
	task automatic chk(pbs_pin_t s, pbs_pin_t e);
		checks_done++;
		if (s[pbs_pkg::DATA_W] !== e[pbs_pkg::DATA_W] || (e[pbs_pkg::DATA_W] && s !== e)) begin
			miscompares++;
			$display("wrong value at %0t: pins %h expected %h", $time, s, e);
		end
	endtask
	task automatic run(logic s);
		arst_n = 1'h0;
		host_u.strap_n = s;
		host_u.idle(4);
		arst_n = 1'h1;
		host_u.idle(1);
		for (int i = 0; i < 4; i++) host_u.cyc(op(1, 0, 0, 1, 8 + i));
		b = op(1, 0, 1, 1, 8);
		b.wdata = '1;
		b.lane_we_n = 1'h0;
		b.lane_sel_n = 4'hA;
		host_u.cyc(b);
		// burst from address 9 with three steps
		n = host_u.log.size();
		host_u.cyc(op(1, 0, 1, 1, 9));
		repeat (3) host_u.cyc(op(1, 1, 1, 0, 0));
		host_u.idle(3);
		for (int k = 0; k < 4; k++) chk(lg(k + 1), mem(s ? 1 ^ k : (1 + k) % 4));
		// processor read, then both strobes with global write low
		n = host_u.log.size();
		host_u.cyc(op(0, 1, 1, 1, 8));
		host_u.cyc(op(0, 0, 0, 1, 10));
		host_u.idle(3);
		chk(lg(0), mem(0));
		chk(lg(1), mem(2));
		// ignored strobe, deselect, reads, then enable high for one cycle
		n = host_u.log.size();
		b = op(0, 1, 1, 1, 11);
		b.sel1_n = 1'h1;
		host_u.cyc(b);
		b = op(1, 0, 1, 1, 11);
		b.sel2 = 1'h0;
		b.sel3_n = 1'h1;
		host_u.cyc(b);
		host_u.cyc(op(1, 0, 1, 1, 11));
		host_u.cyc(op(1, 0, 1, 1, 10));
		host_u.idle(2);
		host_u.cyc(host_u.IDLE, 1'h1);
		host_u.idle(2);
		chk(lg(0), mem(2));
		chk(lg(1), '0);
		chk(lg(2), '0);
		chk(lg(3), mem(2));
		chk(lg(5), '0);
		chk(lg(6), mem(2));
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		run(1'h0);
		run(1'h1);
		print_verdict();
	end
	// hang guard, well past both passes
	initial begin
		#20us;
		miscompares++;
		print_verdict();
	end
endmodule
